// ===== verilog/jclc_pkg.sv
package jclc_pkg;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [9:0] ADDR_CHAN_EN = 10'h209;
   localparam logic [9:0] ADDR_SYNC_HDR = 10'h20f;
   localparam logic [9:0] ADDR_SYNC_THR = 10'h210;
   localparam logic [9:0] ADDR_LINK_CTL = 10'h2f0;
   localparam logic [9:0] ADDR_STATUS = 10'h2f1;
   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [7:0] RST_CHAN_EN = 8'h03;
   localparam logic [7:0] RST_SYNC_HDR = 8'h00;
   localparam logic [7:0] RST_SYNC_THR = 8'h03;
   localparam logic [7:0] RST_LINK_CTL = 8'h00;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int BIT_FIRST_PAIR = 0;
   localparam int BIT_SECOND_PAIR = 1;
   localparam int BIT_ONE_CHANNEL = 2;
   localparam int BIT_LINK_EN = 0;
   localparam int BIT_CAL_EN = 1;
   localparam int SH_LSB = 0;
   localparam int THR_LSB = 0;
   localparam int THR_W = 5;
   // ------------------------------------------------------------
   // sync header codes
   // ------------------------------------------------------------
   localparam logic [1:0] SH_CRC12 = 2'h0;
   localparam logic [1:0] SH_FEC = 2'h2;
   localparam int CMD_W = 8;
   // link sequencing, gray along disabled, apply, running
   typedef enum logic [1:0] {
      ST_DISABLED = 2'h0,
      ST_APPLY = 2'h1,
      ST_RUNNING = 2'h3
   } jclc_link_st_t;
endpackage : jclc_pkg

// ===== verilog/jclc_cfg_if.sv
`timescale 1ns/10ps
// applied link settings and the scaled frame layout
interface jclc_cfg_if;
   logic first_pair;
   logic second_pair;
   logic one_channel;
   logic [3:0] mode_lanes;
   logic [3:0] mode_convs;
   logic [3:0] link_lanes;
   logic [3:0] link_convs;
   logic [3:0] chan_on;
   logic tail_bits;
   logic relocate_cd;
   modport ctrl (output first_pair, second_pair, one_channel, mode_lanes, mode_convs,
      input link_lanes, link_convs, chan_on, tail_bits, relocate_cd);
   modport scale (input first_pair, second_pair, one_channel, mode_lanes, mode_convs,
      output link_lanes, link_convs, chan_on, tail_bits, relocate_cd);
endinterface : jclc_cfg_if

// ===== verilog/jclc_scale.sv
`timescale 1ns/10ps
module jclc_scale (
   input wire logic clk,
   input wire logic rst,
   jclc_cfg_if.scale cfg
);
   typedef struct packed {
      logic [3:0] lanes;
      logic [3:0] convs;
      logic [3:0] chan;
      logic tail;
      logic reloc;
   } jclc_scale_t;
   jclc_scale_t st_ff;
   jclc_scale_t nxt_st;
   logic pair_off;
   // ------------------------------------------------------------
   // lane and converter scaling
   // ------------------------------------------------------------
   always_comb begin
      pair_off = !cfg.first_pair || !cfg.second_pair || cfg.one_channel;
      nxt_st.lanes = cfg.mode_lanes;
      nxt_st.convs = cfg.mode_convs;
      if (pair_off) begin
         nxt_st.lanes = 4'((5'(cfg.mode_lanes) + 5'h01) >> 1);
         nxt_st.convs = cfg.mode_convs >> 1;
      end
      nxt_st.tail = pair_off && cfg.mode_lanes[0];
      nxt_st.reloc = !cfg.first_pair;
      nxt_st.chan[0] = cfg.first_pair;
      nxt_st.chan[1] = cfg.first_pair && !cfg.one_channel;
      nxt_st.chan[2] = cfg.second_pair && !cfg.one_channel;
      nxt_st.chan[3] = cfg.second_pair && !cfg.one_channel;
   end
   // state register
   always_ff @(posedge clk) begin
      if (rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
   assign cfg.link_lanes = st_ff.lanes;
   assign cfg.link_convs = st_ff.convs;
   assign cfg.chan_on = st_ff.chan;
   assign cfg.tail_bits = st_ff.tail;
   assign cfg.relocate_cd = st_ff.reloc;

   a_single_chan_off: assert property (@(posedge clk) disable iff (rst)
      cfg.one_channel |=> cfg.chan_on[3:1] == 3'h0)
      else $error("single channel left b, c or d on");
endmodule : jclc_scale

// ===== verilog/jclc_sync_det.sv
`timescale 1ns/10ps
module jclc_sync_det (
   input wire logic clk,
   input wire logic rst,
   input wire logic sync_n_pin,
   input wire logic armed,
   input wire logic [4:0] thresh,
   output logic sync_level,
   output logic sync_req
);
   typedef struct packed {
      logic meta;
      logic sync_n;
      logic [4:0] cnt;
      logic req;
   } jclc_det_t;
   jclc_det_t st_ff;
   jclc_det_t nxt_st;
   logic [5:0] low_run_ff;
   // ------------------------------------------------------------
   // low-run counter on the synchronised sync input
   // ------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_st.meta = sync_n_pin;
      nxt_st.sync_n = st_ff.meta;
      if (st_ff.sync_n || !armed) begin
         nxt_st.cnt = 5'h00; // short lows count as error reports
         nxt_st.req = 1'b0;
      end else if (st_ff.cnt >= thresh) begin
         nxt_st.req = 1'b1; // low for thresh+1 samples
      end else begin
         nxt_st.cnt = st_ff.cnt + 5'h01;
      end
   end
   // state register, sampled on the link-rate clock
   always_ff @(posedge clk) begin
      if (rst) begin
         st_ff <= '{meta: 1'b1, sync_n: 1'b1, cnt: 5'h00, req: 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end
   // helper: length of current low run, checks only
   always_ff @(posedge clk) begin
      if (rst || st_ff.sync_n) begin
         low_run_ff <= 6'h00;
      end else if (low_run_ff != 6'h3f) begin
         low_run_ff <= low_run_ff + 6'h01;
      end
   end
   assign sync_level = st_ff.sync_n;
   assign sync_req = st_ff.req;

   a_req_needs_run: assert property (@(posedge clk) disable iff (rst)
      sync_req |-> low_run_ff > 6'(thresh))
      else $error("sync request before threshold plus one lows");
   a_req_drops_high: assert property (@(posedge clk) disable iff (rst)
      st_ff.sync_n |=> !sync_req)
      else $error("sync request held while input high");
endmodule : jclc_sync_det

// ===== verilog/jclc_top.sv
// Strobed register access was left to the implementer.
`timescale 1ns/10ps
module jclc_top (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic [9:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   input wire logic [3:0] MODE_LANE_COUNT,
   input wire logic [3:0] MODE_CONVERTER_COUNT,
   input wire logic MODE_IS_64B66B,
   input wire logic SYNC_N,
   output logic LINK_ENABLE,
   output logic CAL_ENABLE,
   output logic [3:0] CHANNEL_ON,
   output logic [3:0] LINK_LANES,
   output logic [3:0] LINK_CONVERTERS,
   output logic TAIL_BITS,
   output logic RELOCATE_CD,
   output logic SYNC_WORD_CRC,
   output logic SYNC_WORD_FEC,
   output logic [7:0] CMD_FIELD,
   output logic SYNC_REQUEST
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] chan_en;
      logic [7:0] sync_hdr;
      logic [7:0] sync_thr;
      logic [7:0] link_ctl;
      logic [7:0] rdata;
      logic [2:0] act_chan;
      logic [1:0] act_hdr;
      logic act_64b;
      logic [3:0] act_lanes;
      logic [3:0] act_convs;
      logic [4:0] act_thr;
      logic crc;
      logic fec;
      jclc_pkg::jclc_link_st_t link;
   } jclc_top_t;
   jclc_top_t st_ff;
   jclc_top_t nxt_st;
   logic sync_level;
   logic sync_req;
   logic [7:0] status;
   jclc_cfg_if cfg ();

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   function automatic logic hit(input logic [9:0] a, input logic [9:0] off);
      hit = (a == off);
   endfunction : hit

   // status word: running, request, tail, relocate, lane count
   assign status = {cfg.link_lanes, cfg.relocate_cd, cfg.tail_bits, sync_req,
      st_ff.link == jclc_pkg::ST_RUNNING};

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      // register writes; reserved bits are stored as written
      if (REG_WR) begin
         if (hit(REG_ADDR, jclc_pkg::ADDR_CHAN_EN)) begin
            nxt_st.chan_en = REG_WDATA;
         end
         if (hit(REG_ADDR, jclc_pkg::ADDR_SYNC_HDR)) begin
            nxt_st.sync_hdr = REG_WDATA;
         end
         if (hit(REG_ADDR, jclc_pkg::ADDR_SYNC_THR)) begin
            nxt_st.sync_thr = REG_WDATA;
         end
         if (hit(REG_ADDR, jclc_pkg::ADDR_LINK_CTL)) begin
            nxt_st.link_ctl = REG_WDATA;
         end
      end
      // read data stands only in the cycle after the strobe
      nxt_st.rdata = 8'h00;
      if (REG_RD) begin
         if (hit(REG_ADDR, jclc_pkg::ADDR_CHAN_EN)) begin
            nxt_st.rdata = st_ff.chan_en;
         end else if (hit(REG_ADDR, jclc_pkg::ADDR_SYNC_HDR)) begin
            nxt_st.rdata = st_ff.sync_hdr;
         end else if (hit(REG_ADDR, jclc_pkg::ADDR_SYNC_THR)) begin
            nxt_st.rdata = st_ff.sync_thr;
         end else if (hit(REG_ADDR, jclc_pkg::ADDR_LINK_CTL)) begin
            nxt_st.rdata = st_ff.link_ctl;
         end else if (hit(REG_ADDR, jclc_pkg::ADDR_STATUS)) begin
            nxt_st.rdata = {sync_level, status[6:0]};
         end
      end
      // link sequencing: settings snapshot on enable
      case (st_ff.link)
         jclc_pkg::ST_DISABLED: begin
            if (st_ff.link_ctl[jclc_pkg::BIT_LINK_EN]) begin
               nxt_st.link = jclc_pkg::ST_APPLY;
               nxt_st.act_chan = st_ff.chan_en[2:0];
               nxt_st.act_hdr = st_ff.sync_hdr[jclc_pkg::SH_LSB +: 2];
               nxt_st.act_thr = st_ff.sync_thr[jclc_pkg::THR_LSB +: jclc_pkg::THR_W];
               nxt_st.act_64b = MODE_IS_64B66B;
               nxt_st.act_lanes = MODE_LANE_COUNT;
               nxt_st.act_convs = MODE_CONVERTER_COUNT;
            end
         end
         jclc_pkg::ST_APPLY: begin
            nxt_st.link = jclc_pkg::ST_RUNNING;
         end
         jclc_pkg::ST_RUNNING: begin
            if (!st_ff.link_ctl[jclc_pkg::BIT_LINK_EN]) begin
               nxt_st.link = jclc_pkg::ST_DISABLED;
            end
         end
         default: begin
            nxt_st.link = jclc_pkg::ST_DISABLED;
         end
      endcase
      // sync word content, only for 64b/66b links
      nxt_st.crc = nxt_st.act_64b && nxt_st.act_hdr == jclc_pkg::SH_CRC12;
      nxt_st.fec = nxt_st.act_64b && nxt_st.act_hdr == jclc_pkg::SH_FEC;
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         st_ff.chan_en <= jclc_pkg::RST_CHAN_EN;
         st_ff.sync_hdr <= jclc_pkg::RST_SYNC_HDR;
         st_ff.sync_thr <= jclc_pkg::RST_SYNC_THR;
         st_ff.link_ctl <= jclc_pkg::RST_LINK_CTL;
         st_ff.rdata <= 8'h00;
         st_ff.act_chan <= jclc_pkg::RST_CHAN_EN[2:0];
         st_ff.act_hdr <= jclc_pkg::RST_SYNC_HDR[1:0];
         st_ff.act_64b <= 1'b0;
         st_ff.act_lanes <= 4'h0;
         st_ff.act_convs <= 4'h0;
         st_ff.act_thr <= jclc_pkg::RST_SYNC_THR[4:0];
         st_ff.crc <= 1'b0;
         st_ff.fec <= 1'b0;
         st_ff.link <= jclc_pkg::ST_DISABLED;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ------------------------------------------------------------
   // applied settings to the scaler
   // ------------------------------------------------------------
   assign cfg.first_pair = st_ff.act_chan[jclc_pkg::BIT_FIRST_PAIR];
   assign cfg.second_pair = st_ff.act_chan[jclc_pkg::BIT_SECOND_PAIR];
   assign cfg.one_channel = st_ff.act_chan[jclc_pkg::BIT_ONE_CHANNEL];
   assign cfg.mode_lanes = st_ff.act_lanes;
   assign cfg.mode_convs = st_ff.act_convs;

   jclc_scale u_scale (
      .clk(REF_CLK),
      .rst(RST),
      .cfg(cfg.scale)
   );

   jclc_sync_det u_sync (
      .clk(REF_CLK),
      .rst(RST),
      .sync_n_pin(SYNC_N),
      .armed(st_ff.link == jclc_pkg::ST_RUNNING),
      .thresh(st_ff.act_thr),
      .sync_level(sync_level),
      .sync_req(sync_req)
   );

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign REG_RDATA = st_ff.rdata;
   assign LINK_ENABLE = st_ff.link == jclc_pkg::ST_RUNNING;
   assign CAL_ENABLE = st_ff.link_ctl[jclc_pkg::BIT_CAL_EN];
   assign CHANNEL_ON = cfg.chan_on;
   assign LINK_LANES = cfg.link_lanes;
   assign LINK_CONVERTERS = cfg.link_convs;
   assign TAIL_BITS = cfg.tail_bits;
   assign RELOCATE_CD = cfg.relocate_cd;
   assign SYNC_WORD_CRC = st_ff.crc;
   assign SYNC_WORD_FEC = st_ff.fec;
   assign CMD_FIELD = {jclc_pkg::CMD_W{1'b0}}; // idle headers only
   assign SYNC_REQUEST = sync_req;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence s_enable_seen;
      st_ff.link == jclc_pkg::ST_DISABLED && st_ff.link_ctl[jclc_pkg::BIT_LINK_EN];
   endsequence
   sequence s_running_in_two;
      ##2 st_ff.link == jclc_pkg::ST_RUNNING;
   endsequence

   a_enable_applies: assert property (@(posedge REF_CLK) disable iff (RST)
      s_enable_seen |-> s_running_in_two)
      else $error("link did not reach running two cycles after enable");
   a_frozen_running: assert property (@(posedge REF_CLK) disable iff (RST)
      st_ff.link == jclc_pkg::ST_RUNNING && $past(st_ff.link) == jclc_pkg::ST_RUNNING
      |-> $stable(st_ff.act_chan) && $stable(st_ff.act_hdr))
      else $error("applied settings changed while running");
   a_lanes_halved: assert property (@(posedge REF_CLK) disable iff (RST)
      !st_ff.act_chan[jclc_pkg::BIT_SECOND_PAIR] && $stable(st_ff.act_lanes)
      |=> LINK_LANES == 4'((5'($past(st_ff.act_lanes)) + 5'h01) >> 1))
      else $error("lane count not halved rounding up");
   a_convs_halved: assert property (@(posedge REF_CLK) disable iff (RST)
      !st_ff.act_chan[jclc_pkg::BIT_FIRST_PAIR] && $stable(st_ff.act_convs)
      |=> LINK_CONVERTERS == ($past(st_ff.act_convs) >> 1))
      else $error("converter count not halved");
   a_tail_odd: assert property (@(posedge REF_CLK) disable iff (RST)
      st_ff.act_chan[1:0] == 2'h3 && !st_ff.act_chan[2] |=> !TAIL_BITS)
      else $error("tail bits with both pairs on");
   a_relocate_cd: assert property (@(posedge REF_CLK) disable iff (RST)
      $stable(st_ff.act_chan) |=> RELOCATE_CD == !$past(st_ff.act_chan[0]))
      else $error("c, d relocation does not follow first pair");
   a_pair_chan: assert property (@(posedge REF_CLK) disable iff (RST)
      !st_ff.act_chan[1] |=> CHANNEL_ON[3:2] == 2'h0)
      else $error("channels c, d on with second pair off");
   a_first_pair: assert property (@(posedge REF_CLK) disable iff (RST)
      !st_ff.act_chan[0] |=> CHANNEL_ON[1:0] == 2'h0)
      else $error("channels a, b on with first pair off");
   a_hdr_only_64b: assert property (@(posedge REF_CLK) disable iff (RST)
      !st_ff.act_64b |-> !SYNC_WORD_CRC && !SYNC_WORD_FEC)
      else $error("sync word selected outside 64b/66b");
   a_hdr_reserved: assert property (@(posedge REF_CLK) disable iff (RST)
      st_ff.act_hdr[0] |-> !SYNC_WORD_CRC && !SYNC_WORD_FEC)
      else $error("reserved header code selected a sync word");
   a_cmd_zero: assert property (@(posedge REF_CLK) disable iff (RST)
      CMD_FIELD == 8'h00)
      else $error("command field not zero");
   a_thr_reset: assert property (@(posedge REF_CLK)
      $past(RST) && !RST |-> st_ff.sync_thr == 8'h03)
      else $error("threshold register reset value wrong");
   a_read_one: assert property (@(posedge REF_CLK) disable iff (RST)
      !REG_RD |=> REG_RDATA == 8'h00)
      else $error("read data outside the read answer cycle");
endmodule : jclc_top

// ===== sim/jclc_rx_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// receiver side: drives the active-low sync line
// ------------------------------------------------------------
module jclc_rx_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic go,
   input wire logic [7:0] low_len,
   output logic sync_n
);
   logic [7:0] left_ff;
   // hold sync low for low_len cycles after go, idle high otherwise
   always_ff @(posedge clk) begin
      if (rst) begin
         sync_n <= 1'b1;
         left_ff <= 8'h00;
      end else if (go) begin
         sync_n <= 1'b0;
         left_ff <= low_len - 8'h01;
      end else if (left_ff != 8'h00) begin
         left_ff <= left_ff - 8'h01;
      end else begin
         sync_n <= 1'b1;
      end
   end
endmodule : jclc_rx_model

// ===== sim/tb.sv
`timescale 1ns/10ps
module tb;
   logic REF_CLK, RST, REG_WR, REG_RD, MODE_IS_64B66B, SYNC_N, go;
   logic [9:0] REG_ADDR;
   logic [7:0] REG_WDATA, REG_RDATA, CMD_FIELD, low_len;
   logic [3:0] MODE_LANE_COUNT, MODE_CONVERTER_COUNT, CHANNEL_ON, LINK_LANES, LINK_CONVERTERS;
   logic LINK_ENABLE, CAL_ENABLE, TAIL_BITS, RELOCATE_CD;
   logic SYNC_WORD_CRC, SYNC_WORD_FEC, SYNC_REQUEST;
   int n_mismatch, n_compared;
   // ------------------------------------------------------------
   // design and receiver model
   // ------------------------------------------------------------
   jclc_top u_dut (.REF_CLK(REF_CLK), .RST(RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
      .MODE_LANE_COUNT(MODE_LANE_COUNT), .MODE_CONVERTER_COUNT(MODE_CONVERTER_COUNT),
      .MODE_IS_64B66B(MODE_IS_64B66B), .SYNC_N(SYNC_N), .LINK_ENABLE(LINK_ENABLE),
      .CAL_ENABLE(CAL_ENABLE), .CHANNEL_ON(CHANNEL_ON), .LINK_LANES(LINK_LANES),
      .LINK_CONVERTERS(LINK_CONVERTERS), .TAIL_BITS(TAIL_BITS), .RELOCATE_CD(RELOCATE_CD),
      .SYNC_WORD_CRC(SYNC_WORD_CRC), .SYNC_WORD_FEC(SYNC_WORD_FEC), .CMD_FIELD(CMD_FIELD),
      .SYNC_REQUEST(SYNC_REQUEST));
   jclc_rx_model u_rx (.clk(REF_CLK), .rst(RST), .go(go), .low_len(low_len), .sync_n(SYNC_N));
   // 10 MHz clock
   initial begin
      REF_CLK = 1'b0;
      forever #50 REF_CLK = ~REF_CLK;
   end
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic stop_test;
      $display("mismatches %0d compared %0d", n_mismatch, n_compared);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : stop_test
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge REF_CLK);
      REG_WR <= 1'b1;
      REG_ADDR <= a;
      REG_WDATA <= d;
      @(posedge REF_CLK);
      REG_WR <= 1'b0;
   endtask : wr
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [9:0] a, input logic [7:0] exp);
      @(posedge REF_CLK);
      REG_RD <= 1'b1;
      REG_ADDR <= a;
      @(posedge REF_CLK);
      REG_RD <= 1'b0;
      #1;
      chk("read data", exp, REG_RDATA);
   endtask : rd
   task automatic wait_link;
      int i;
      #1;
      for (i = 0; i < 10 && LINK_ENABLE !== 1'b1; i++) begin
         @(posedge REF_CLK);
         #1;
      end
      if (LINK_ENABLE !== 1'b1) begin
         n_mismatch++;
         $display("CHECK FAILED link enable expected 1 seen %b", LINK_ENABLE);
         stop_test();
      end
   endtask : wait_link
   // program one configuration with the link off, enable, check the frame layout
   task automatic run_cfg(input logic [7:0] ch, input logic [7:0] sh, input logic [3:0] l,
      input logic [3:0] m, input logic is64);
      logic ab, cd, one, off;
      logic [3:0] lanes, convs;
      ab = ch[0];
      cd = ch[1];
      one = ch[2];
      off = !ab || !cd || one;
      lanes = off ? 4'((5'(l) + 5'h01) >> 1) : l;
      convs = off ? (m >> 1) : m;
      wr(jclc_pkg::ADDR_LINK_CTL, 8'h00);
      MODE_LANE_COUNT <= l;
      MODE_CONVERTER_COUNT <= m;
      MODE_IS_64B66B <= is64;
      wr(jclc_pkg::ADDR_CHAN_EN, ch);
      wr(jclc_pkg::ADDR_SYNC_HDR, sh);
      wr(jclc_pkg::ADDR_LINK_CTL, 8'h01);
      wait_link();
      chk("channel on", {4'h0, cd && !one, cd && !one, ab && !one, ab}, {4'h0, CHANNEL_ON});
      chk("link lanes", {4'h0, lanes}, {4'h0, LINK_LANES});
      chk("link converters", {4'h0, convs}, {4'h0, LINK_CONVERTERS});
      chk("tail bits", {7'h00, off && l[0]}, {7'h00, TAIL_BITS});
      chk("relocate", {7'h00, !ab}, {7'h00, RELOCATE_CD});
      chk("crc word", {7'h00, is64 && sh == 8'h00}, {7'h00, SYNC_WORD_CRC});
      chk("fec word", {7'h00, is64 && sh == 8'h02}, {7'h00, SYNC_WORD_FEC});
      chk("command", 8'h00, CMD_FIELD);
      rd(jclc_pkg::ADDR_CHAN_EN, ch);
      rd(jclc_pkg::ADDR_SYNC_HDR, sh);
   endtask : run_cfg
   // pulse sync low for len cycles, count edges until a request (13 means none)
   task automatic sync_pulse(input logic [7:0] len, input logic [7:0] exp);
      int n;
      @(posedge REF_CLK);
      go <= 1'b1;
      low_len <= len;
      @(posedge REF_CLK);
      go <= 1'b0;
      for (n = 1; n <= 12; n++) begin
         @(posedge REF_CLK);
         #1;
         if (SYNC_REQUEST === 1'b1) break;
      end
      chk("sync latency", exp, 8'(n));
      for (n = 0; n < 40 && SYNC_REQUEST !== 1'b0; n++) begin
         @(posedge REF_CLK);
         #1;
      end
      chk("sync release", 8'h00, {7'h00, SYNC_REQUEST});
   endtask : sync_pulse
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      n_mismatch = 0;
      n_compared = 0;
      RST = 1'b1;
      REG_WR = 1'b0;
      REG_RD = 1'b0;
      REG_ADDR = 10'h000;
      REG_WDATA = 8'h00;
      MODE_LANE_COUNT = 4'h8;
      MODE_CONVERTER_COUNT = 4'h4;
      MODE_IS_64B66B = 1'b1;
      go = 1'b0;
      low_len = 8'h01;
      repeat (2) @(posedge REF_CLK);
      RST <= 1'b0;
      @(posedge REF_CLK);
      #1;
      chk("reset channel on", 8'h0f, {4'h0, CHANNEL_ON});
      chk("reset request", 8'h00, {7'h00, SYNC_REQUEST});
      chk("reset cal enable", 8'h00, {7'h00, CAL_ENABLE});
      rd(jclc_pkg::ADDR_CHAN_EN, 8'h03);
      rd(jclc_pkg::ADDR_SYNC_HDR, 8'h00);
      rd(jclc_pkg::ADDR_SYNC_THR, 8'h03);
      rd(10'h300, 8'h00);
      run_cfg(8'h03, 8'h00, 4'h8, 4'h4, 1'b1);
      run_cfg(8'h01, 8'h02, 4'h5, 4'h4, 1'b1);
      run_cfg(8'h02, 8'h01, 4'h4, 4'h4, 1'b1);
      run_cfg(8'h05, 8'h03, 4'h3, 4'h4, 1'b1);
      wr(jclc_pkg::ADDR_LINK_CTL, 8'h00);
      wr(jclc_pkg::ADDR_SYNC_THR, 8'h02);
      rd(jclc_pkg::ADDR_SYNC_THR, 8'h02);
      run_cfg(8'h03, 8'h00, 4'h3, 4'h2, 1'b0);
      // settings written while running are held back until re-enable
      wr(jclc_pkg::ADDR_CHAN_EN, 8'h01);
      repeat (4) @(posedge REF_CLK);
      #1;
      chk("held channel on", 8'h0f, {4'h0, CHANNEL_ON});
      chk("held lanes", 8'h03, {4'h0, LINK_LANES});
      // status: sync high, lanes 3, running
      rd(jclc_pkg::ADDR_STATUS, 8'hb1);
      sync_pulse(8'h02, 8'h0d);
      sync_pulse(8'h03, 8'h05);
      sync_pulse(8'h14, 8'h05);
      wr(jclc_pkg::ADDR_LINK_CTL, 8'h00);
      wr(jclc_pkg::ADDR_LINK_CTL, 8'h01);
      wait_link();
      chk("applied channel on", 8'h03, {4'h0, CHANNEL_ON});
      chk("applied lanes", 8'h02, {4'h0, LINK_LANES});
      wr(jclc_pkg::ADDR_LINK_CTL, 8'h03);
      #1;
      chk("cal enable", 8'h01, {7'h00, CAL_ENABLE});
      stop_test();
   end
endmodule : tb
